/* File: common/gauge_defs.vh */
`ifndef GAUGE_DEFS_VH
`define GAUGE_DEFS_VH
// Command codes
`define CMD_MAKER_ACCESS 8'h00
`define CMD_PACK_MODE 8'h03
`define CMD_TEMPERATURE 8'h08
`define CMD_PACK_VOLTAGE 8'h09
`define CMD_INSTANT_CURRENT 8'h0A
`define CMD_MEAN_CURRENT 8'h0B
`define CMD_ESTIMATE_ERROR 8'h0C
`define CMD_CHARGE_LEVEL 8'h0D
`define CMD_CAPACITY_LEFT 8'h0F
`define CMD_CAPACITY_FULL 8'h10
`define CMD_WANTED_CURRENT 8'h14
`define CMD_WANTED_VOLTAGE 8'h15
`define CMD_PACK_STATUS 8'h16
`define CMD_CYCLE_TALLY 8'h17
`define CMD_NOMINAL_CAP 8'h18
`define CMD_SPEC_VERSION 8'h1A
`define CMD_BUILD_DATE 8'h1B
`define CMD_UNIT_SERIAL 8'h1C
`define CMD_MAKER_NAME 8'h20
// Reset values
`define RST_CAPACITY_FULL 16'h1C20
`define RST_WANTED_CURRENT 16'h09C4
`define RST_WANTED_VOLTAGE 16'h3138
`define RST_CYCLE_TALLY 16'h0000
`define RST_NOMINAL_CAP 16'h1C20
`define RST_NOMINAL_VOLT 16'h0E10
`define RST_SPEC_VERSION 16'h0031
`define RST_BUILD_DATE 16'h0000
`define RST_UNIT_SERIAL 16'h0001
// Maker access subcommands
`define MAC_DORMANT_ENTER 16'h0010
`define MAC_DORMANT_EXIT 16'h0011
// Control status field
`define CTRL_DORMANT_REQ_BIT 4
// Thresholds, mV and mA
`define DORM_VOLT_MIN 16'h0960
`define DORM_VOLT_MAX 16'h0BB8
`define DORM_VOLT_DEF 16'h09F6
`define DORM_CURR_MAX 16'h02BC
`define DORM_CURR_DEF 16'h0008
`define SHUT_VOLT 16'h0960
// Timing
`define TICK_PERIOD_S 1
`define SLEEP_PERIOD_S 20
`define SHUT_TIME_MS 24
`define STRETCH_TIME_MS 4
`define CLK_HZ 100000000
// Mode codes
`define MODE_NORMAL 3'h0
`define MODE_SLEEP 3'h1
`define MODE_DEEP_IDLE 3'h2
`define MODE_DORMANT 3'h3
`define MODE_SHUTDOWN 3'h4
`endif

/* File: rtl/gauge_power_mode.v */
// Contract
// - Only normal-sleep, sleep-deep idle, deep idle-dormant/shutdown, sleep-shutdown.
// - Normal mode measures and updates reported values every second.
// - Sleep entered only with sleep enable set and mean current at sleep level.
// - Sleep left on enable cleared, current above sleep level, or wake current.
// - Sleep mode measures once every twenty seconds.
// - Deep idle entered only after the programmed number of one-second ticks is seen in sleep.
// - Deep idle left at once on command traffic addressed to the device.
// - Dormant from deep idle on low load, low cell voltage or host request.
// - Dormant left on voltage or load above threshold, bus activity or host command.
// - Dormant voltage threshold programmable 2.4 V to 3 V, default 2.55 V.
// - Dormant current threshold programmable 0 to 0.7 A, default 8 mA.
// - Shutdown from sleep or deep idle when cell below 2.4 V over 24 ms and no charger.
// - Shutdown left on bus activity, wake current or charger connection.
// - Shutdown turns regulator and discharge drive off until bus activity, wake current or charger ends it.
// - Measured command data refreshed only once per second; reads are answered on any command strobe.
// - Sleep or deep idle may stretch the bus up to four milliseconds.
// - Leaving dormant clears the dormant request flag; here a dormant enter write in the same cycle keeps it set.
`timescale 1ns/1ps
`include "gauge_defs.vh"
module gauge_power_mode #(
    parameter TICK_CYCLES = `CLK_HZ * `TICK_PERIOD_S,
    parameter SHUT_CYCLES = `CLK_HZ / 1000 * `SHUT_TIME_MS,
    parameter STRETCH_CYCLES = `CLK_HZ / 1000 * `STRETCH_TIME_MS
) (
    input wire sys_clk, // 100 MHz clock
    input wire rst, // Synchronous reset, active high
    input wire cmd_valid, // Command access strobe, one cycle
    input wire cmd_write, // 1 write, 0 read
    input wire [7:0] cmd_code, // Command code
    input wire [15:0] cmd_wdata, // Write word
    input wire bus_activity, // Addressed bus traffic seen, pulse
    input wire [15:0] meas_temperature, // Live temperature
    input wire [15:0] meas_voltage, // Live cell voltage, mV
    input wire [15:0] meas_current, // Live current, mA signed
    input wire [15:0] meas_mean_current, // Live mean current, signed
    input wire [15:0] meas_error_pct, // Live estimate error
    input wire [15:0] meas_charge_pct, // Live charge level
    input wire [15:0] meas_status, // Live pack status flags
    input wire wake_current, // Current above wake threshold
    input wire charger_attached, // Charger present on pack
    input wire sleep_enable, // Sleep enable setting
    input wire [15:0] sleep_current, // Sleep current level, mA
    input wire [7:0] deep_idle_wait_time, // Seconds, 0 disables
    input wire [15:0] dormant_volt_set, // Dormant voltage, mV
    input wire [15:0] dormant_curr_set, // Dormant current, mA
    output reg [15:0] cmd_rdata, // Read word
    output reg cmd_rvalid, // Read data valid, one cycle
    output reg [2:0] power_mode, // Current mode code
    output reg meas_strobe, // Measurement request pulse
    output reg internal_regulator, // Regulator enable
    output reg discharge_switch_drive, // Discharge switch enable
    output reg bus_stretch, // Hold bus lines low
    output reg [15:0] control_status // Control status word
);

reg [31:0] tick_cnt;
reg tick;
reg [4:0] sleep_sec;
reg [7:0] idle_sec;
reg [31:0] shut_cnt;
reg [31:0] stretch_cnt;
reg [2:0] next_mode;
reg [15:0] maker_access_word;
reg [15:0] pack_mode_word;
reg [15:0] capacity_left;
reg [15:0] cycle_tally;
reg [15:0] nominal_capacity;
reg [15:0] spec_version_info;
reg [15:0] build_date;
reg [15:0] unit_serial;
reg [7:0] maker_name_string;
reg [15:0] snap_temp, snap_volt, snap_curr, snap_mean;
reg [15:0] snap_err, snap_chg, snap_stat;
reg host_dormant_req;
reg host_dormant_exit;

// Clamp a setting into the documented range
function [15:0] clamp;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
endfunction

// Magnitude of a signed mA value
function [15:0] mag;
    input [15:0] v;
    begin
        mag = v[15] ? (~v + 16'h0001) : v;
    end
endfunction

wire [15:0] dorm_v = clamp(dormant_volt_set, `DORM_VOLT_MIN,
    `DORM_VOLT_MAX);
wire [15:0] dorm_i = clamp(dormant_curr_set, 16'h0000,
    `DORM_CURR_MAX);
wire [15:0] mean_mag = mag(meas_mean_current);
wire [15:0] load_mag = mag(meas_current);
wire shut_cond = (meas_voltage < `SHUT_VOLT) && !charger_attached;
// Charger arriving on the last count still blocks shutdown
wire shut_hit = shut_cond && (shut_cnt >= SHUT_CYCLES);
wire mac_write = cmd_valid && cmd_write && cmd_code == `CMD_MAKER_ACCESS;
wire dorm_req_set = mac_write && cmd_wdata == `MAC_DORMANT_ENTER;
wire dorm_req_clr = power_mode == `MODE_DORMANT &&
    next_mode != `MODE_DORMANT;
wire next_dormant_req = dorm_req_set || (host_dormant_req && !dorm_req_clr);

always @(posedge sys_clk) begin
    if (rst) begin
        tick_cnt <= 32'h0000_0000;
        tick <= 1'b0;
    end else if (tick_cnt >= TICK_CYCLES - 1) begin
        tick_cnt <= 32'h0000_0000;
        tick <= 1'b1;
    end else begin
        tick_cnt <= tick_cnt + 32'h0000_0001;
        tick <= 1'b0;
    end
end

always @* begin
    next_mode = power_mode;
    case (power_mode)
        `MODE_NORMAL: begin
            if (sleep_enable && mean_mag <= sleep_current &&
                !wake_current)
                next_mode = `MODE_SLEEP;
        end
        `MODE_SLEEP: begin
            if (!sleep_enable || mean_mag > sleep_current ||
                wake_current)
                next_mode = `MODE_NORMAL;
            else if (shut_hit)
                next_mode = `MODE_SHUTDOWN;
            else if (deep_idle_wait_time != 8'h00 &&
                idle_sec >= deep_idle_wait_time)
                next_mode = `MODE_DEEP_IDLE;
        end
        `MODE_DEEP_IDLE: begin
            if (bus_activity)
                next_mode = `MODE_NORMAL;
            else if (shut_hit)
                next_mode = `MODE_SHUTDOWN;
            else if (load_mag <= dorm_i || meas_voltage < dorm_v ||
                host_dormant_req)
                next_mode = `MODE_DORMANT;
        end
        `MODE_DORMANT: begin
            if (meas_voltage > dorm_v || load_mag > dorm_i ||
                bus_activity || host_dormant_exit)
                next_mode = `MODE_NORMAL;
        end
        `MODE_SHUTDOWN: begin
            // Regulator is off, so only pin-level wakes reach us
            if (bus_activity || wake_current || charger_attached)
                next_mode = `MODE_NORMAL;
        end
        default: next_mode = `MODE_NORMAL;
    endcase
end

always @(posedge sys_clk) begin
    if (rst) begin
        power_mode <= `MODE_NORMAL;
        idle_sec <= 8'h00;
        sleep_sec <= 5'h00;
        shut_cnt <= 32'h0000_0000;
        meas_strobe <= 1'b0;
        internal_regulator <= 1'b1;
        discharge_switch_drive <= 1'b1;
    end else begin
        power_mode <= next_mode;
        internal_regulator <= (next_mode != `MODE_SHUTDOWN);
        discharge_switch_drive <= (next_mode != `MODE_SHUTDOWN);
        if (shut_cond)
            shut_cnt <= shut_hit ? shut_cnt : shut_cnt + 32'h0000_0001;
        else
            shut_cnt <= 32'h0000_0000;
        if (next_mode != `MODE_SLEEP || power_mode != `MODE_SLEEP)
            idle_sec <= 8'h00;
        else if (tick && idle_sec != 8'hFF)
            idle_sec <= idle_sec + 8'h01;
        meas_strobe <= 1'b0;
        if (power_mode == `MODE_NORMAL) begin
            sleep_sec <= 5'h00;
            meas_strobe <= tick;
        end else if (power_mode == `MODE_SLEEP ||
            power_mode == `MODE_DEEP_IDLE) begin
            if (tick) begin
                if (sleep_sec >= `SLEEP_PERIOD_S - 1) begin
                    sleep_sec <= 5'h00;
                    meas_strobe <= 1'b1;
                end else begin
                    sleep_sec <= sleep_sec + 5'h01;
                end
            end
        end else begin
            sleep_sec <= 5'h00;
        end
    end
end

// Stretch: halted core needs time to answer an access
always @(posedge sys_clk) begin
    if (rst) begin
        stretch_cnt <= 32'h0000_0000;
        bus_stretch <= 1'b0;
    end else if (bus_stretch) begin
        if (stretch_cnt >= STRETCH_CYCLES - 1) begin
            bus_stretch <= 1'b0;
            stretch_cnt <= 32'h0000_0000;
        end else begin
            stretch_cnt <= stretch_cnt + 32'h0000_0001;
        end
    end else if (bus_activity && (power_mode == `MODE_SLEEP ||
        power_mode == `MODE_DEEP_IDLE)) begin
        bus_stretch <= 1'b1;
        stretch_cnt <= 32'h0000_0000;
    end
end

// Host dormant request flag; set wins over clear
always @(posedge sys_clk) begin
    if (rst) begin
        host_dormant_req <= 1'b0;
        host_dormant_exit <= 1'b0;
        control_status <= 16'h0000;
    end else begin
        host_dormant_exit <= mac_write &&
            cmd_wdata == `MAC_DORMANT_EXIT;
        host_dormant_req <= next_dormant_req;
        // Built from next values so status lines up with power_mode
        control_status <= {11'h000, next_dormant_req, 1'b0,
            next_mode};
    end
end

// Snapshot of live data, refreshed once per second only
always @(posedge sys_clk) begin
    if (rst) begin
        snap_temp <= 16'h0000;
        snap_volt <= 16'h0000;
        snap_curr <= 16'h0000;
        snap_mean <= 16'h0000;
        snap_err <= 16'h0000;
        snap_chg <= 16'h0000;
        snap_stat <= 16'h0000;
    end else if (tick) begin
        snap_temp <= meas_temperature;
        snap_volt <= meas_voltage;
        snap_curr <= meas_current;
        snap_mean <= meas_mean_current;
        snap_err <= meas_error_pct;
        snap_chg <= meas_charge_pct;
        snap_stat <= meas_status;
    end
end

always @(posedge sys_clk) begin
    if (rst) begin
        maker_access_word <= 16'h0000;
        pack_mode_word <= 16'h0000;
        capacity_left <= 16'h0000;
        cycle_tally <= `RST_CYCLE_TALLY;
        nominal_capacity <= `RST_NOMINAL_CAP;
        spec_version_info <= `RST_SPEC_VERSION;
        build_date <= `RST_BUILD_DATE;
        unit_serial <= `RST_UNIT_SERIAL;
        maker_name_string <= 8'h00;
        cmd_rdata <= 16'h0000;
        cmd_rvalid <= 1'b0;
    end else begin
        cmd_rvalid <= cmd_valid && !cmd_write;
        if (cmd_valid && cmd_write) begin
            case (cmd_code)
                `CMD_MAKER_ACCESS: maker_access_word <= cmd_wdata;
                `CMD_PACK_MODE: pack_mode_word <= cmd_wdata;
                `CMD_CAPACITY_LEFT: capacity_left <= cmd_wdata;
                `CMD_CYCLE_TALLY: cycle_tally <= cmd_wdata;
                `CMD_NOMINAL_CAP: nominal_capacity <= cmd_wdata;
                `CMD_SPEC_VERSION: spec_version_info <= cmd_wdata;
                `CMD_BUILD_DATE: build_date <= cmd_wdata;
                `CMD_UNIT_SERIAL: unit_serial <= cmd_wdata;
                `CMD_MAKER_NAME: maker_name_string <= cmd_wdata[7:0];
                default: cmd_rdata <= cmd_rdata;
            endcase
        end
        if (cmd_valid && !cmd_write) begin
            case (cmd_code)
                `CMD_MAKER_ACCESS: cmd_rdata <= maker_access_word;
                `CMD_PACK_MODE: cmd_rdata <= pack_mode_word;
                `CMD_TEMPERATURE: cmd_rdata <= snap_temp;
                `CMD_PACK_VOLTAGE: cmd_rdata <= snap_volt;
                `CMD_INSTANT_CURRENT: cmd_rdata <= snap_curr;
                `CMD_MEAN_CURRENT: cmd_rdata <= snap_mean;
                `CMD_ESTIMATE_ERROR: cmd_rdata <= snap_err;
                `CMD_CHARGE_LEVEL: cmd_rdata <= snap_chg;
                `CMD_CAPACITY_LEFT: cmd_rdata <= capacity_left;
                `CMD_CAPACITY_FULL: cmd_rdata <= `RST_CAPACITY_FULL;
                `CMD_WANTED_CURRENT: cmd_rdata <= `RST_WANTED_CURRENT;
                `CMD_WANTED_VOLTAGE: cmd_rdata <= `RST_WANTED_VOLTAGE;
                `CMD_PACK_STATUS: cmd_rdata <= snap_stat;
                `CMD_CYCLE_TALLY: cmd_rdata <= cycle_tally;
                // Nominal voltage has no read code here; this code returns capacity
                `CMD_NOMINAL_CAP: cmd_rdata <= nominal_capacity;
                `CMD_SPEC_VERSION: cmd_rdata <= spec_version_info;
                `CMD_BUILD_DATE: cmd_rdata <= build_date;
                `CMD_UNIT_SERIAL: cmd_rdata <= unit_serial;
                `CMD_MAKER_NAME: cmd_rdata <= {8'h00, maker_name_string};
                default: cmd_rdata <= 16'h0000;
            endcase
        end
    end
end

endmodule

/* File: testbench/gauge_power_mode_asserts.sv */
`timescale 1ns/1ps
`include "gauge_defs.vh"
module gauge_power_mode_asserts (
    input wire sys_clk, // Clock
    input wire rst, // Reset
    input wire bus_activity, // Traffic
    input wire wake_current, // Wake
    input wire charger_attached, // Charger
    input wire sleep_enable, // Sleep on
    input wire [2:0] power_mode, // Mode
    input wire meas_strobe, // Measure
    input wire internal_regulator, // Regulator
    input wire discharge_switch_drive, // Drive
    input wire bus_stretch, // Stretch
    input wire [15:0] control_status // Status
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Exits go to normal; dormant never steps on to shutdown
    mode_order_a: assert property (power_mode != $past(power_mode) |->
        power_mode == `MODE_NORMAL || ($past(power_mode) != `MODE_DORMANT
        && power_mode == $past(power_mode) + 3'h1) ||
        (power_mode == `MODE_SHUTDOWN && ($past(power_mode) == `MODE_SLEEP
        || $past(power_mode) == `MODE_DEEP_IDLE)))
        else $error("illegal mode move");
    normal_tick_a: assert property (meas_strobe && power_mode == `MODE_NORMAL
        ##20 power_mode == `MODE_NORMAL |-> meas_strobe)
        else $error("normal measurement period wrong");
    sleep_entry_a: assert property (power_mode == `MODE_SLEEP &&
        $past(power_mode) == `MODE_NORMAL |-> $past(sleep_enable))
        else $error("sleep entered while disabled");
    sleep_exit_a: assert property (power_mode == `MODE_SLEEP &&
        (!sleep_enable || wake_current) |=> power_mode != `MODE_SLEEP)
        else $error("sleep not left");
    deep_exit_a: assert property (power_mode == `MODE_DEEP_IDLE &&
        bus_activity |=> power_mode != `MODE_DEEP_IDLE)
        else $error("deep idle not left on traffic");
    dormant_flag_a: assert property ($past(power_mode) == `MODE_DORMANT &&
        power_mode != `MODE_DORMANT |-> !control_status[4])
        else $error("dormant flag kept after exit");
    shut_entry_a: assert property (power_mode == `MODE_SHUTDOWN &&
        $past(power_mode) != `MODE_SHUTDOWN |-> !$past(charger_attached))
        else $error("shutdown with charger present");
    shut_outputs_a: assert property (power_mode == `MODE_SHUTDOWN |->
        !internal_regulator && !discharge_switch_drive)
        else $error("regulator or drive on in shutdown");
    stretch_hold_a: assert property ((power_mode == `MODE_SLEEP ||
        power_mode == `MODE_DEEP_IDLE) && bus_activity |=> bus_stretch[*4])
        else $error("bus stretch too short");
endmodule
bind gauge_power_mode gauge_power_mode_asserts chk_i (.sys_clk, .rst,
    .bus_activity, .wake_current, .charger_attached, .sleep_enable,
    .power_mode, .meas_strobe, .internal_regulator, .discharge_switch_drive,
    .bus_stretch, .control_status);

/* File: testbench/host_cmd_model.sv */
`timescale 1ns/1ps
module host_cmd_model (
    input wire sys_clk, // Clock
    input wire [15:0] cmd_rdata, // Read word
    input wire cmd_rvalid, // Read valid
    output reg cmd_valid, // Strobe
    output reg cmd_write, // Write
    output reg [7:0] cmd_code, // Code
    output reg [15:0] cmd_wdata // Write word
);
    reg [15:0] last_rdata;
    reg last_rv;
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // One word access; idle lines get inverted so stale values never match
    task access(input wr, input [7:0] code, input [15:0] data);
        begin
            @(posedge sys_clk);
            cmd_valid <= 1'b1;
            cmd_write <= wr;
            cmd_code <= code;
            cmd_wdata <= data;
            @(posedge sys_clk);
            cmd_valid <= 1'b0;
            cmd_code <= ~code;
            cmd_wdata <= ~data;
            #1;
            last_rv = cmd_rvalid;
            last_rdata = cmd_rdata;
        end
    endtask
endmodule

/* File: testbench/tb_gauge_power_mode.sv */
`timescale 1ns/1ps
`include "gauge_defs.vh"
module tb_gauge_power_mode;
    reg sys_clk = 1'b0;
    reg rst = 1'b1;
    reg bus_activity = 1'b0;
    reg [15:0] meas_voltage = 16'h0E10;
    reg [15:0] meas_mean_current = 16'h0064;
    reg wake_current = 1'b0;
    reg charger_attached = 1'b0;
    reg sleep_enable = 1'b0;
    reg [15:0] sleep_current = 16'h000A;
    reg [7:0] deep_idle_wait_time = 8'h00;
    reg [15:0] dormant_volt_set = `DORM_VOLT_DEF;
    reg [15:0] dormant_curr_set = `DORM_CURR_DEF;
    reg [15:0] meas_current = 16'h0064;
    wire cmd_valid, cmd_write, cmd_rvalid, meas_strobe, bus_stretch;
    wire internal_regulator, discharge_switch_drive;
    wire [7:0] cmd_code;
    wire [15:0] cmd_wdata, cmd_rdata, control_status;
    wire [2:0] power_mode;
    integer bad_count = 0;
    integer total_checks = 0;
    integer cycles = 0;
    integer n;
    always #5 sys_clk = ~sys_clk;
    gauge_power_mode #(.TICK_CYCLES(20), .SHUT_CYCLES(5), .STRETCH_CYCLES(4))
        gauge_power_mode_i (.sys_clk(sys_clk), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .bus_activity(bus_activity),
        .meas_temperature(16'h0BA2), .meas_voltage(meas_voltage),
        .meas_current(meas_current), .meas_mean_current(meas_mean_current),
        .meas_error_pct(16'h0003), .meas_charge_pct(16'h0050),
        .meas_status(16'h0080), .wake_current(wake_current),
        .charger_attached(charger_attached), .sleep_enable(sleep_enable),
        .sleep_current(sleep_current),
        .deep_idle_wait_time(deep_idle_wait_time),
        .dormant_volt_set(dormant_volt_set),
        .dormant_curr_set(dormant_curr_set),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .power_mode(power_mode), .meas_strobe(meas_strobe),
        .internal_regulator(internal_regulator),
        .discharge_switch_drive(discharge_switch_drive),
        .bus_stretch(bus_stretch), .control_status(control_status));
    host_cmd_model host_cmd_model_i (.sys_clk(sys_clk),
        .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task rd(input [7:0] code, input [15:0] exp);
        begin
            host_cmd_model_i.access(1'b0, code, 16'h0000);
            chk({15'h0000, host_cmd_model_i.last_rv}, 16'h0001);
            chk(host_cmd_model_i.last_rdata, exp);
        end
    endtask
    task wait_mode(input [2:0] m, input integer lim);
        begin
            n = 0;
            #1;
            while (power_mode !== m && n < lim) begin
                @(posedge sys_clk);
                #1;
                n = n + 1;
            end
            chk({13'h0000, power_mode}, {13'h0000, m});
        end
    endtask
    task wait_strobe;
        begin
            n = 0;
            @(posedge sys_clk);
            #1;
            while (meas_strobe !== 1'b1 && n < 100) begin
                @(posedge sys_clk);
                #1;
                n = n + 1;
            end
        end
    endtask
    task pulse_bus;
        begin
            @(posedge sys_clk);
            bus_activity <= 1'b1;
            @(posedge sys_clk);
            bus_activity <= 1'b0;
            #1;
        end
    endtask
    task t_reset_values;
        begin
            chk({13'h0000, power_mode}, 16'h0000);
            chk({14'h0000, internal_regulator, discharge_switch_drive},
                16'h0003);
            rd(`CMD_CAPACITY_FULL, `RST_CAPACITY_FULL);
            rd(`CMD_WANTED_VOLTAGE, `RST_WANTED_VOLTAGE);
            rd(`CMD_CYCLE_TALLY, `RST_CYCLE_TALLY);
            rd(`CMD_SPEC_VERSION, `RST_SPEC_VERSION);
            rd(`CMD_UNIT_SERIAL, `RST_UNIT_SERIAL);
            // Read-only places must not take writes; an unmapped place reads zero
            host_cmd_model_i.access(1'b1, `CMD_WANTED_CURRENT, 16'h1234);
            rd(`CMD_WANTED_CURRENT, `RST_WANTED_CURRENT);
            rd(8'h01, 16'h0000);
        end
    endtask
    task t_snapshot;
        begin
            wait_strobe;
            rd(`CMD_PACK_VOLTAGE, 16'h0E10);
            meas_voltage <= 16'h0F00;
            rd(`CMD_PACK_VOLTAGE, 16'h0E10);
            wait_strobe;
            wait_strobe;
            chk(n[15:0], 16'h0013);
            rd(`CMD_PACK_VOLTAGE, 16'h0F00);
        end
    endtask
    task t_sleep_deep;
        begin
            @(posedge sys_clk);
            sleep_enable <= 1'b1;
            meas_mean_current <= 16'h0005;
            deep_idle_wait_time <= 8'h02;
            wait_mode(`MODE_SLEEP, 100);
            wait_mode(`MODE_DEEP_IDLE, 200);
            chk({15'h0000, n > 20}, 16'h0001);
            meas_voltage <= 16'h0A00;
            dormant_volt_set <= 16'h0A00;
            dormant_curr_set <= 16'h0064;
            wait_mode(`MODE_DORMANT, 10);
            host_cmd_model_i.access(1'b1, `CMD_MAKER_ACCESS, `MAC_DORMANT_ENTER);
            chk({15'h0000, control_status[4]}, 16'h0001);
            meas_current <= 16'h0065;
            wait_mode(`MODE_NORMAL, 5);
            chk({15'h0000, control_status[4]}, 16'h0000);
            meas_voltage <= 16'h0E10;
            dormant_volt_set <= `DORM_VOLT_DEF;
            dormant_curr_set <= `DORM_CURR_DEF;
            meas_current <= 16'h0064;
            wait_mode(`MODE_DEEP_IDLE, 300);
            pulse_bus;
            chk({15'h0000, bus_stretch}, 16'h0001);
            chk({15'h0000, power_mode == `MODE_DEEP_IDLE}, 16'h0000);
        end
    endtask
    task t_shutdown;
        begin
            @(posedge sys_clk);
            deep_idle_wait_time <= 8'h00;
            wait_mode(`MODE_SLEEP, 100);
            meas_voltage <= `SHUT_VOLT - 16'h0001;
            wait_mode(`MODE_SHUTDOWN, 30);
            chk({15'h0000, n >= 5}, 16'h0001);
            chk({14'h0000, internal_regulator, discharge_switch_drive},
                16'h0000);
            charger_attached <= 1'b1;
            meas_voltage <= 16'h0E10;
            wait_mode(`MODE_NORMAL, 5);
            chk({15'h0000, internal_regulator}, 16'h0001);
            wait_mode(`MODE_SLEEP, 100);
            wake_current <= 1'b1;
            wait_mode(`MODE_NORMAL, 3);
            wake_current <= 1'b0;
            wait_mode(`MODE_SLEEP, 100);
            sleep_enable <= 1'b0;
            wait_mode(`MODE_NORMAL, 3);
            sleep_enable <= 1'b1;
            wait_mode(`MODE_SLEEP, 100);
            sleep_current <= 16'h0004;
            wait_mode(`MODE_NORMAL, 3);
            sleep_current <= 16'h000A;
        end
    endtask
    task print_verdict;
        begin
            if (bad_count == 0 && total_checks > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    // Whole run needs about two hundred cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count = bad_count + 1;
            print_verdict;
        end
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        t_reset_values;
        t_snapshot;
        t_sleep_deep;
        t_shutdown;
        print_verdict;
    end
endmodule
